// *** src/cmsd_defines.vh ***
// Purpose: Constants for the core memory space decoder
// Assumes: 8-bit data space, 16-bit program space
// Notes:   Included by the decoder only; the RAM does not include it
`ifndef CMSD_DEFINES_VH
`define CMSD_DEFINES_VH
`define CMSD_SP_ADDR        8'h81
`define CMSD_PSW_ADDR       8'hD0
`define CMSD_SP_RESET       8'h07
`define CMSD_PSW_RESET      8'h00
`define CMSD_PSW_BANK_LO    3
`define CMSD_PSW_BANK_HI    4
`define CMSD_BIT_BASE       8'h20
`define CMSD_UPPER_HALF     8'h80
`define CMSD_NOP_OP         8'h00
`define CMSD_SPARE_OP       8'hA5
`define CMSD_PAGE_BITS      11
`define CMSD_FACTORY_BASE   16'h1E00
`define CMSD_PM_SIZE        8192
// Access kinds
`define CMSD_OP_IDLE        3'h0
`define CMSD_OP_DIRECT      3'h1
`define CMSD_OP_INDIRECT    3'h2
`define CMSD_OP_BANKREG     3'h3
`define CMSD_OP_BIT         3'h4
`define CMSD_OP_PUSH        3'h5
`define CMSD_OP_POP         3'h6
`endif

// *** src/cmsd_ram.v ***
// Purpose: Single-port data RAM with registered read data
// Assumes: Synchronous write and read on one clock
// Notes:   Read data appears one cycle after the address
`timescale 1ns/1ps
module cmsd_ram #(
    parameter AW = 8,
    parameter DW = 8
) (
    input  wire          i_sys_clk,
    input  wire          i_we,
    input  wire [AW-1:0] i_addr,
    input  wire [DW-1:0] i_wdata,
    output reg  [DW-1:0] o_rdata
);
    reg [DW-1:0] mem [0:(1<<AW)-1];

    always @(posedge i_sys_clk) begin
        if (i_we) begin
            mem[i_addr] <= i_wdata;
        end
        o_rdata <= mem[i_addr];
    end
endmodule

// *** src/cmsd_decoder.v ***
// Purpose: Address-space decoder for the data, bit, stack and program spaces
// Assumes: Core issues one access at a time and waits for o_done
// Notes:   External SFRs are reached on the sfr port; RAM holds all 256 bytes
`timescale 1ns/1ps
`include "cmsd_defines.vh"
module cmsd_decoder #(
    parameter PM_SIZE = `CMSD_PM_SIZE
) (
    input  wire        i_sys_clk,
    input  wire        i_reset_n,
    // Data access request
    input  wire        i_req,
    input  wire [2:0]  i_op,
    input  wire        i_write,
    input  wire [7:0]  i_addr,
    input  wire [7:0]  i_wdata,
    input  wire        i_bit_val,
    output reg         o_done,
    output reg  [7:0]  o_rdata,
    output reg         o_bit_rdata,
    output reg         o_bit_error,
    // External SFR port
    output reg         o_sfr_rd,
    output reg         o_sfr_wr,
    output reg  [7:0]  o_sfr_addr,
    output reg  [7:0]  o_sfr_wdata,
    input  wire [7:0]  i_sfr_rdata,
    // Branch target calculation and spare opcode remap
    input  wire [15:0] i_next_pc,
    input  wire [7:0]  i_rel,
    input  wire [10:0] i_page_target,
    input  wire [15:0] i_full_target,
    input  wire [7:0]  i_opcode,
    output reg  [15:0] o_short_target,
    output reg  [15:0] o_page_dest,
    output reg  [15:0] o_long_dest,
    output reg         o_long_in_range,
    output reg  [7:0]  o_opcode_eff,
    // Program memory read port
    input  wire [15:0] i_code_addr,
    output reg  [15:0] o_pm_addr,
    output reg         o_pm_valid,
    output reg         o_pm_factory,
    // State
    output reg  [7:0]  o_stack_top_pointer,
    output reg  [7:0]  o_program_status_word
);
    localparam ST_IDLE  = 2'h0;
    localparam ST_INDEX = 2'h1;
    localparam ST_RAM   = 2'h2;
    localparam ST_SFR   = 2'h3;

    reg [1:0] state_r;
    reg       write_r;
    reg       is_bit_r;
    reg [2:0] bitpos_r;
    reg [7:0] wdata_r;
    reg       bitval_r;
    reg [7:0] stack_top_pointer_r;
    reg [7:0] program_status_word_r;

    reg        ram_we;
    reg [7:0]  ram_addr;
    reg [7:0]  ram_wdata;
    wire [7:0] ram_rdata;

    // Bank register n at eight times bank plus n
    function [7:0] bank_addr;
        input [7:0] program_status_word;
        input [2:0] n;
        begin
            bank_addr = {3'h0, program_status_word[`CMSD_PSW_BANK_HI], program_status_word[`CMSD_PSW_BANK_LO], n};
        end
    endfunction

    // Bit address to byte address: low half into 0x20-0x2F, high half into SFRs
    function [7:0] bit_byte;
        input [7:0] ba;
        begin
            if (ba[7]) begin
                bit_byte = {ba[7:3], 3'h0};
            end else begin
                bit_byte = `CMSD_BIT_BASE + {4'h0, ba[6:3]};
            end
        end
    endfunction

    function [7:0] set_bit;
        input [7:0] byte_in;
        input [2:0] pos;
        input       val;
        begin
            set_bit = byte_in;
            set_bit[pos] = val;
        end
    endfunction

    cmsd_ram #(.AW(8), .DW(8)) u_ram (
        .i_sys_clk (i_sys_clk),
        .i_we      (ram_we),
        .i_addr    (ram_addr),
        .i_wdata   (ram_wdata),
        .o_rdata   (ram_rdata)
    );

    // Byte target of a fresh request; bit kind set by op, never by address
    wire [7:0] req_byte = (i_op == `CMSD_OP_BIT) ? bit_byte(i_addr) : i_addr;
    wire       req_bit  = (i_op == `CMSD_OP_BIT);
    // All upper-half direct and bit accesses go out, SP and PSW included; their data is served here
    wire       req_sfr  = (i_op == `CMSD_OP_DIRECT || req_bit) &&
                          (req_byte >= `CMSD_UPPER_HALF);
    wire [7:0] push_addr = stack_top_pointer_r + 8'h01;

    reg [7:0] merged;
    reg [7:0] byte_addr_r;
    always @* begin
        merged = set_bit(ram_rdata, bitpos_r, bitval_r);
    end

    function [7:0] int_sfr_rd;
        input [7:0] a;
        input [7:0] sp;
        input [7:0] program_status_word;
        input [7:0] ext;
        begin
            if (a == `CMSD_SP_ADDR) begin
                int_sfr_rd = sp;
            end else if (a == `CMSD_PSW_ADDR) begin
                int_sfr_rd = program_status_word;
            end else begin
                int_sfr_rd = ext;
            end
        end
    endfunction

    // Internal SP and PROGRAM_STATUS_WORD override the external read data
    wire [7:0] sfr_byte = int_sfr_rd(o_sfr_addr, stack_top_pointer_r,
                                     program_status_word_r, i_sfr_rdata);

    // RAM port steering, combinational from state
    always @* begin
        ram_we    = 1'b0;
        ram_addr  = 8'h00;
        ram_wdata = wdata_r;
        if (state_r == ST_IDLE && i_req) begin
            case (i_op)
                `CMSD_OP_INDIRECT: ram_addr = bank_addr(program_status_word_r, {2'h0, i_addr[0]});
                `CMSD_OP_BANKREG: begin
                    ram_addr = bank_addr(program_status_word_r, i_addr[2:0]);
                    ram_we   = i_write;
                    ram_wdata = i_wdata;
                end
                `CMSD_OP_PUSH: begin
                    ram_addr  = push_addr;
                    ram_we    = 1'b1;
                    ram_wdata = i_wdata;
                end
                `CMSD_OP_POP: ram_addr = stack_top_pointer_r;
                default: ram_addr = req_byte;
            endcase
        end else if (state_r == ST_INDEX) begin
            ram_addr = ram_rdata; // full 8-bit indirect into RAM
        end else if (state_r == ST_RAM) begin
            ram_addr = byte_addr_r;
            if (write_r) begin
                ram_we    = 1'b1;
                ram_wdata = is_bit_r ? merged : wdata_r;
            end
        end
    end

    always @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            state_r               <= ST_IDLE;
            write_r               <= 1'b0;
            is_bit_r              <= 1'b0;
            bitpos_r              <= 3'h0;
            wdata_r               <= 8'h00;
            bitval_r              <= 1'b0;
            byte_addr_r           <= 8'h00;
            stack_top_pointer_r   <= `CMSD_SP_RESET;
            program_status_word_r <= `CMSD_PSW_RESET;
            o_done                <= 1'b0;
            o_rdata               <= 8'h00;
            o_bit_rdata           <= 1'b0;
            o_bit_error           <= 1'b0;
            o_sfr_rd              <= 1'b0;
            o_sfr_wr              <= 1'b0;
            o_sfr_addr            <= 8'h00;
            o_sfr_wdata           <= 8'h00;
        end else begin
            o_done   <= 1'b0;
            o_sfr_rd <= 1'b0;
            o_sfr_wr <= 1'b0;
            case (state_r)
                ST_IDLE: begin
                    o_bit_error <= 1'b0;
                    if (i_req) begin
                        write_r     <= i_write;
                        is_bit_r    <= req_bit;
                        bitpos_r    <= i_addr[2:0];
                        wdata_r     <= i_wdata;
                        bitval_r    <= i_bit_val;
                        byte_addr_r <= req_byte;
                        case (i_op)
                            `CMSD_OP_PUSH: begin
                                stack_top_pointer_r <= push_addr;
                                o_done <= 1'b1;
                            end
                            `CMSD_OP_POP: begin
                                stack_top_pointer_r <= stack_top_pointer_r - 8'h01;
                                state_r <= ST_RAM;
                                write_r <= 1'b0;
                            end
                            `CMSD_OP_INDIRECT: state_r <= ST_INDEX;
                            `CMSD_OP_BANKREG: state_r <= i_write ? ST_IDLE : ST_RAM;
                            `CMSD_OP_DIRECT, `CMSD_OP_BIT: begin
                                if (req_sfr) begin
                                    state_r    <= ST_SFR;
                                    o_sfr_addr <= req_byte;
                                    o_sfr_rd   <= 1'b1;
                                end else begin
                                    state_r <= ST_RAM;
                                end
                            end
                            default: o_done <= 1'b1;
                        endcase
                        if (i_op == `CMSD_OP_BANKREG && i_write) begin
                            o_done <= 1'b1;
                        end
                    end
                end
                ST_INDEX: begin
                    byte_addr_r <= ram_rdata;
                    state_r     <= ST_RAM;
                end
                ST_RAM: begin
                    o_rdata     <= ram_rdata;
                    o_bit_rdata <= ram_rdata[bitpos_r];
                    o_done      <= 1'b1;
                    state_r     <= ST_IDLE;
                end
                ST_SFR: begin
                    // Read-modify-write covers bit writes to SFRs
                    o_rdata     <= sfr_byte;
                    o_bit_rdata <= sfr_byte[bitpos_r];
                    if (write_r) begin
                        if (o_sfr_addr == `CMSD_SP_ADDR) begin
                            stack_top_pointer_r <= is_bit_r ?
                                set_bit(stack_top_pointer_r, bitpos_r, bitval_r) : wdata_r;
                        end else if (o_sfr_addr == `CMSD_PSW_ADDR) begin
                            program_status_word_r <= is_bit_r ?
                                set_bit(program_status_word_r, bitpos_r, bitval_r) : wdata_r;
                        end else begin
                            o_sfr_wr    <= 1'b1;
                            o_sfr_wdata <= is_bit_r ?
                                set_bit(i_sfr_rdata, bitpos_r, bitval_r) : wdata_r;
                        end
                    end
                    o_done  <= 1'b1;
                    state_r <= ST_IDLE;
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // Branch targets, opcode remap, program space and state copies
    always @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            o_short_target  <= 16'h0000;
            o_page_dest     <= 16'h0000;
            o_long_dest     <= 16'h0000;
            o_long_in_range <= 1'b0;
            o_opcode_eff    <= `CMSD_NOP_OP;
            o_pm_addr       <= 16'h0000;
            o_pm_valid      <= 1'b0;
            o_pm_factory    <= 1'b0;
            o_stack_top_pointer   <= `CMSD_SP_RESET;
            o_program_status_word <= `CMSD_PSW_RESET;
        end else begin
            o_short_target  <= i_next_pc + {{8{i_rel[7]}}, i_rel};
            o_page_dest     <= {i_next_pc[15:`CMSD_PAGE_BITS], i_page_target};
            o_long_dest     <= i_full_target;
            o_long_in_range <= ({16'h0000, i_full_target} < PM_SIZE);
            o_opcode_eff    <= (i_opcode == `CMSD_SPARE_OP) ? `CMSD_NOP_OP : i_opcode;
            o_pm_addr       <= i_code_addr; // read-only path, no write port
            o_pm_valid      <= ({16'h0000, i_code_addr} < PM_SIZE);
            o_pm_factory    <= (PM_SIZE == `CMSD_PM_SIZE) &&
                               (i_code_addr >= `CMSD_FACTORY_BASE) &&
                               ({16'h0000, i_code_addr} < PM_SIZE);
            o_stack_top_pointer   <= stack_top_pointer_r;
            o_program_status_word <= program_status_word_r;
        end
    end
endmodule

// *** dv/cmsd_sfr_model.sv ***
// Purpose: Stand-in for the peripheral special function registers
// Assumes: Read data is wanted only while the read strobe stands
// Notes:   Unwritten locations read unknown; only reads of written ones and of the overridden SP and PSW are checked
`timescale 1ns/1ps
module cmsd_sfr_model (
    input  wire       i_sys_clk,
    input  wire       i_sfr_rd,
    input  wire       i_sfr_wr,
    input  wire [7:0] i_sfr_addr,
    input  wire [7:0] i_sfr_wdata,
    output wire [7:0] o_sfr_rdata
);
    reg [7:0] mem [0:255];
    reg [7:0] junk_r = 8'h5A;
    // Only occupied addresses are ever used by the bench
    always @(posedge i_sys_clk) begin
        if (i_sfr_wr)
            mem[i_sfr_addr] <= i_sfr_wdata;
        junk_r <= ~junk_r;
    end
    // Valid only while the strobe stands; toggling junk exposes late sampling
    assign o_sfr_rdata = i_sfr_rd ? mem[i_sfr_addr] : junk_r;
endmodule

// *** dv/cmsd_decoder_properties.sv ***
// Purpose: Port-level checks of the memory space decoder
// Assumes: One request is taken when idle or in the cycle of o_done
// Notes:   Bound to every decoder instance
`timescale 1ns/1ps
module cmsd_checker #(
    parameter PM_SIZE = 8192
) (
    input wire        i_sys_clk,
    input wire        i_reset_n,
    input wire        i_req,
    input wire [2:0]  i_op,
    input wire        i_write,
    input wire [7:0]  i_addr,
    input wire [15:0] i_next_pc,
    input wire [7:0]  i_rel,
    input wire [10:0] i_page_target,
    input wire [15:0] i_full_target,
    input wire [7:0]  i_opcode,
    input wire [15:0] i_code_addr,
    input wire        o_done,
    input wire        o_sfr_rd,
    input wire        o_sfr_wr,
    input wire [7:0]  o_sfr_addr,
    input wire [15:0] o_short_target,
    input wire [15:0] o_page_dest,
    input wire [15:0] o_long_dest,
    input wire [7:0]  o_opcode_eff,
    input wire        o_pm_valid
);
    reg         busy_r;
    wire        take    = i_req && (!busy_r || o_done);
    wire [15:0] rel_ext = {{8{i_rel[7]}}, i_rel};
    always @(posedge i_sys_clk)
        if (!i_reset_n)
            busy_r <= 1'b0;
        else
            busy_r <= take ? 1'b1 : (o_done ? 1'b0 : busy_r);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_reset_n);
    spare_op_a: assert property ($past(i_reset_n) |-> o_opcode_eff ==
        (($past(i_opcode) == 8'hA5) ? 8'h00 : $past(i_opcode))) else $error("opcode remap");
    rel_add_a: assert property ($past(i_reset_n) |->
        o_short_target == $past(i_next_pc) + $past(rel_ext)) else $error("short target");
    page_keep_a: assert property ($past(i_reset_n) |-> o_page_dest ==
        (($past(i_next_pc) & 16'hF800) | {5'h00, $past(i_page_target)})) else $error("page");
    long_dest_a: assert property ($past(i_reset_n) |->
        o_long_dest == $past(i_full_target)) else $error("long target");
    pm_size_a: assert property ($past(i_reset_n) |->
        o_pm_valid == ($past(i_code_addr) < PM_SIZE)) else $error("code range");
    push_fast_a: assert property (take && i_op == 3'h5 |=> o_done)
        else $error("push latency");
    ram_direct_a: assert property (take && i_op == 3'h1 && !i_addr[7] |=>
        !o_sfr_rd && !o_done ##1 o_done) else $error("direct ram");
    sfr_direct_a: assert property (take && i_op == 3'h1 && i_addr[7] && !i_write |=>
        o_sfr_rd && o_sfr_addr == $past(i_addr)) else $error("sfr direct");
    upper_ram_a: assert property (take && i_op == 3'h2 |=>
        (!o_sfr_rd && !o_sfr_wr)[*3]) else $error("indirect hit sfr");
    sfr_bit_a: assert property (take && i_op == 3'h4 && i_addr[7] |=>
        o_sfr_rd && o_sfr_addr == ($past(i_addr) & 8'hF8)) else $error("sfr bit");
    cover property (take && i_op == 3'h5);
    cover property (take && i_op == 3'h4 && i_addr[7]);
    cover property (take && i_op == 3'h2);
endmodule
bind cmsd_decoder cmsd_checker #(.PM_SIZE(PM_SIZE)) u_chk (.*);

// *** dv/cmsd_tb.sv ***
// Purpose: Self-checking bench for the memory space decoder
// Assumes: Inputs change on the falling clock edge
// Notes:   Bench plays the core; the sfr model answers the sfr port
`timescale 1ns/1ps
module testbench;
    reg i_sys_clk = 0, i_reset_n = 0, i_req = 0, i_write = 0, i_bit_val = 0;
    reg [2:0] i_op = 0;
    reg [7:0] i_addr = 0, i_wdata = 0, i_rel = 0, i_opcode = 0;
    reg [10:0] i_page_target = 0;
    reg [15:0] i_next_pc = 0, i_full_target = 0, i_code_addr = 0;
    wire o_done, o_bit_rdata, o_bit_error, o_sfr_rd, o_sfr_wr, o_long_in_range;
    wire o_pm_valid, o_pm_factory;
    wire [7:0] o_rdata, o_sfr_addr, o_sfr_wdata, i_sfr_rdata, o_opcode_eff;
    wire [7:0] o_stack_top_pointer, o_program_status_word;
    wire [15:0] o_short_target, o_page_dest, o_long_dest, o_pm_addr;
    integer err_count = 0, total_checks = 0, cyc = 0;
    cmsd_decoder uut (.*);
    cmsd_sfr_model u_sfr (.i_sys_clk(i_sys_clk), .i_sfr_rd(o_sfr_rd), .i_sfr_wr(o_sfr_wr),
        .i_sfr_addr(o_sfr_addr), .i_sfr_wdata(o_sfr_wdata), .o_sfr_rdata(i_sfr_rdata));
    always #25 i_sys_clk = ~i_sys_clk;
    task results;
        begin
            $display("checks %0d mismatches %0d", total_checks, err_count);
            if (err_count == 0 && total_checks > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask
    // Ceiling far above the fewer than a hundred cycles the tests need
    always @(posedge i_sys_clk) begin
        cyc = cyc + 1;
        if (cyc == 3000) begin
            err_count = err_count + 1;
            results;
        end
    end
    task chk(input [15:0] got, input [15:0] exp);
        begin
            total_checks = total_checks + 1;
            if (got !== exp) begin
                err_count = err_count + 1;
                $display("[FAIL] %0t ns: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task acc(input [2:0] op, input w, input [7:0] a, input [7:0] d, input b);
        integer n;
        begin
            @(negedge i_sys_clk);
            i_req = 1; i_op = op; i_write = w; i_addr = a; i_wdata = d; i_bit_val = b;
            @(posedge i_sys_clk);
            #1 n = 0;
            @(negedge i_sys_clk);
            i_req = 0;
            while (o_done !== 1'b1 && n < 8) begin
                @(posedge i_sys_clk);
                #1 n = n + 1;
            end
            chk({15'h0, o_done}, 16'h1);
        end
    endtask
    task t_reset;
        begin
            chk(o_stack_top_pointer, 8'h07);
            acc(3'h1, 0, 8'h81, 0, 0); chk(o_rdata, 8'h07);
            acc(3'h5, 1, 0, 8'h5E, 0); acc(3'h1, 0, 8'h08, 0, 0); chk(o_rdata, 8'h5E);
            acc(3'h1, 0, 8'h81, 0, 0); chk(o_rdata, 8'h08);
            $display("reset and first push done");
        end
    endtask
    task t_space;
        begin
            acc(3'h3, 1, 8'h00, 8'h30, 0); acc(3'h1, 1, 8'h30, 8'hA1, 0);
            acc(3'h2, 0, 8'h00, 0, 0); chk(o_rdata, 8'hA1);
            acc(3'h1, 1, 8'h98, 8'h3C, 0); acc(3'h3, 1, 8'h00, 8'h98, 0);
            acc(3'h2, 1, 8'h00, 8'hC3, 0); acc(3'h1, 0, 8'h98, 0, 0);
            chk(o_rdata, 8'h3C);
            acc(3'h2, 0, 8'h00, 0, 0); chk(o_rdata, 8'hC3);
            $display("address spaces done");
        end
    endtask
    task t_bit;
        begin
            acc(3'h1, 1, 8'h22, 8'h00, 0); acc(3'h4, 1, 8'h13, 0, 1);
            acc(3'h1, 0, 8'h22, 0, 0); chk(o_rdata, 8'h08);
            acc(3'h4, 0, 8'h13, 0, 0); chk({15'h0, o_bit_rdata}, 16'h1);
            chk({15'h0, o_bit_error}, 16'h0);
            acc(3'h4, 1, 8'h9B, 0, 0); acc(3'h1, 0, 8'h98, 0, 0);
            chk(o_rdata, 8'h34);
            $display("bit access done");
        end
    endtask
    task t_bank;
        begin
            acc(3'h1, 1, 8'hD0, 8'h18, 0);
            // The port copy lags the internal word by one cycle
            @(posedge i_sys_clk);
            #1 chk(o_program_status_word, 8'h18);
            acc(3'h3, 1, 8'h05, 8'h77, 0); acc(3'h1, 0, 8'h1D, 0, 0);
            chk(o_rdata, 8'h77);
            acc(3'h1, 1, 8'hD0, 8'h00, 0);
            $display("bank select done");
        end
    endtask
    task t_stack;
        begin
            acc(3'h1, 1, 8'h81, 8'hFE, 0); acc(3'h5, 1, 0, 8'h11, 0); acc(3'h5, 1, 0, 8'h22, 0);
            acc(3'h1, 0, 8'h81, 0, 0); chk(o_rdata, 8'h00);
            acc(3'h6, 0, 0, 0, 0); chk(o_rdata, 8'h22);
            acc(3'h3, 1, 8'h00, 8'hFF, 0); acc(3'h2, 0, 8'h00, 0, 0);
            chk(o_rdata, 8'h11);
            $display("stack wrap done");
        end
    endtask
    task t_branch;
        begin
            @(negedge i_sys_clk);
            i_next_pc = 16'h1000; i_rel = 8'h80; i_page_target = 11'h7FF;
            i_full_target = 16'h1FFF; i_opcode = 8'hA5; i_code_addr = 16'h1E00;
            @(negedge i_sys_clk);
            chk(o_short_target, 16'h0F80); chk(o_page_dest, 16'h17FF);
            chk(o_long_dest, 16'h1FFF); chk(o_opcode_eff, 8'h00);
            chk(o_pm_addr, 16'h1E00); chk({o_pm_valid, o_pm_factory}, 2'b11);
            chk({15'h0, o_long_in_range}, 16'h1);
            i_next_pc = 16'h27FE; i_rel = 8'h7F; i_page_target = 11'h001;
            i_full_target = 16'hFFFF; i_opcode = 8'h12; i_code_addr = 16'h2000;
            @(negedge i_sys_clk);
            chk(o_short_target, 16'h287D); chk(o_page_dest, 16'h2001);
            chk(o_long_dest, 16'hFFFF); chk(o_opcode_eff, 8'h12);
            chk({o_pm_valid, o_pm_factory}, 2'b00);
            chk({15'h0, o_long_in_range}, 16'h0);
            $display("branch targets done");
        end
    endtask
    initial begin
        repeat (16) @(posedge i_sys_clk);
        @(negedge i_sys_clk);
        i_reset_n = 1;
        t_reset;
        t_space;
        t_bit;
        t_bank;
        t_stack;
        t_branch;
        results;
    end
endmodule
